// *** design/eef_bus_front_end.sv ***
// two-wire slave front end with strap matching, write guard and write fifo
// Contract
// - sample on clock rise, drive after fall
// - data line only pulled low or released
// - data changes only while clock low
// - falling data, clock high: start
// - rising data, clock high: stop, standby
// - eight-bit words, acknowledge on ninth clock
// - standby at power-up and after stop
// - address word begins with type code
// - smallest density compares all three straps
// - second density compares two, one page bit
// - third density compares one, two page bits
// - largest density compares none, three page bits
// - page bits are top word address bits
// - last address bit selects read or write
// - ack on match, else standby until start
// - write guard high blocks all writes
// - smallest array: 32 pages of 8
// - second array: 32 pages of 16
// - third array: 64 pages of 16
// - largest array: 128 pages of 16
// - no acknowledge during internal write cycle
`timescale 1ns/10ps
// ****************************************************************
// write fifo
// ****************************************************************
module eef_fifo #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];    // storage, flip-flops
  logic [PW-1:0]    wr_ptr_ff;         // next slot to fill
  logic [PW-1:0]    rd_ptr_ff;         // next slot to drain
  logic [PW:0]      count_ff;          // words held
  logic             do_wr;
  logic             do_rd;
  assign in_ready  = (count_ff != (PW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;
  // storage write, no reset needed on data
  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
  // pointers and fill level
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + PW'(1);
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + PW'(1);
      end
      count_ff <= count_ff + (PW+1)'(do_wr) - (PW+1)'(do_rd);
    end
  end
endmodule : eef_fifo
// ****************************************************************
// bus front end
// ****************************************************************
module eef_bus_front_end #(
  parameter logic [3:0] DEV_TYPE = eef_pkg::DEV_TYPE_RST  // type code, value is arbitrary
) (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic                     strap_bit_high,
  input  wire logic                     strap_bit_mid,
  input  wire logic                     strap_bit_low,
  input  wire logic                     write_guard,
  input  wire eef_pkg::eef_variant_type variant,
  input  wire logic                     write_busy,
  output logic                          wr_valid,
  input  wire logic                     wr_ready,
  output eef_pkg::eef_wr_word_type      wr_word,
  output logic                          standby,
  output logic                          selected,
  output logic                          read_mode,
  output logic [10:0]                   word_addr,
  output logic                          guard_hit
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  // strap compare per density
  function automatic logic addr_match(eef_pkg::eef_variant_type v, logic [2:0] hdr, logic [2:0] strap);
    case (v)
      eef_pkg::EEF_VAR_S:  addr_match = (hdr == strap);
      eef_pkg::EEF_VAR_M:  addr_match = (hdr[2:1] == strap[2:1]);
      eef_pkg::EEF_VAR_L:  addr_match = (hdr[2] == strap[2]);
      default:             addr_match = 1'b1;
    endcase
  endfunction : addr_match
  // header bits reused as upper word address bits
  function automatic logic [10:0] page_bits(eef_pkg::eef_variant_type v, logic [2:0] hdr);
    case (v)
      eef_pkg::EEF_VAR_S:  page_bits = 11'h000;
      eef_pkg::EEF_VAR_M:  page_bits = {2'h0, hdr[0], 8'h00};
      eef_pkg::EEF_VAR_L:  page_bits = {1'h0, hdr[1:0], 8'h00};
      default:             page_bits = {hdr, 8'h00};
    endcase
  endfunction : page_bits
  // bits that walk inside one page
  function automatic logic [10:0] page_ofs(eef_pkg::eef_variant_type v);
    page_ofs = (v == eef_pkg::EEF_VAR_S) ? eef_pkg::PAGE_OFS_8 : eef_pkg::PAGE_OFS_16;
  endfunction : page_ofs
  // address bits the array really has
  function automatic logic [10:0] array_mask(eef_pkg::eef_variant_type v);
    case (v)
      eef_pkg::EEF_VAR_S:  array_mask = eef_pkg::ARRAY_MASK_S;
      eef_pkg::EEF_VAR_M:  array_mask = eef_pkg::ARRAY_MASK_M;
      eef_pkg::EEF_VAR_L:  array_mask = eef_pkg::ARRAY_MASK_L;
      default:             array_mask = eef_pkg::ARRAY_MASK_XL;
    endcase
  endfunction : array_mask
  // ****************************************************************
  // declarations
  // ****************************************************************
  eef_pkg::eef_pins_type    pin_meta_ff;    // first stage, read only by second
  eef_pkg::eef_pins_type    pin_sync_ff;    // settled pin levels
  eef_pkg::eef_pins_type    pin_prev_ff;    // levels one clock earlier
  logic [3:0]               strap_meta_ff;  // straps and guard, first stage
  logic [3:0]               strap_sync_ff;  // straps and guard, settled
  eef_pkg::eef_state_type   state_ff;       // bus state
  logic [3:0]               bit_cnt_ff;     // bits taken in current word
  logic [7:0]               shift_ff;       // received word, msb first
  logic [10:0]              page_ff;        // page bits caught from header
  logic [10:0]              word_addr_ff;   // current word address
  logic                     sda_oe_ff;      // pulling the data line low
  logic                     sda_out_ff;     // driven level, always low
  logic                     read_mode_ff;   // direction bit of last matched header
  logic                     standby_ff;     // low-power standby
  logic                     selected_ff;    // header matched and taken
  logic                     guard_hit_ff;   // a write byte was dropped by the guard
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start_det;
  logic                     stop_det;
  logic                     byte_done;
  logic                     dev_ok;
  logic                     ack_state;
  logic                     ack_now;
  logic                     guard_s;
  logic                     push;
  logic                     fifo_ready;
  logic [2:0]               strap_s;
  eef_pkg::eef_wr_word_type push_word;
  logic [10:0]              ofs;
  // ****************************************************************
  // pin synchronisers and bus events
  // ****************************************************************
  // two flops on every pin; bus idles high so that is the reset level
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta_ff <= 2'h3;
      pin_sync_ff <= 2'h3;
      pin_prev_ff <= 2'h3;
    end else begin
      pin_meta_ff <= '{scl: scl_in, sda: sda_in};
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end
  // straps and guard are slow levels but still come from pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      strap_meta_ff <= 4'h0;
      strap_sync_ff <= 4'h0;
    end else begin
      strap_meta_ff <= {write_guard, strap_bit_high, strap_bit_mid, strap_bit_low};
      strap_sync_ff <= strap_meta_ff;
    end
  end
  assign strap_s  = strap_sync_ff[2:0];
  assign guard_s  = strap_sync_ff[3];
  assign scl_rise = pin_sync_ff.scl && !pin_prev_ff.scl;
  assign scl_fall = !pin_sync_ff.scl && pin_prev_ff.scl;
  assign start_det = pin_sync_ff.scl && pin_prev_ff.scl && pin_prev_ff.sda && !pin_sync_ff.sda;
  assign stop_det  = pin_sync_ff.scl && pin_prev_ff.scl && !pin_prev_ff.sda && pin_sync_ff.sda;
  assign byte_done = scl_fall && (bit_cnt_ff == eef_pkg::BYTE_BITS);
  assign ack_state = (state_ff == eef_pkg::EEF_ST_DEVACK) || (state_ff == eef_pkg::EEF_ST_WACK)
                     || (state_ff == eef_pkg::EEF_ST_DACK);
  assign dev_ok = (shift_ff[7:4] == DEV_TYPE) && addr_match(variant, shift_ff[3:1], strap_s) && !write_busy;
  // with the guard low, a full fifo refuses the byte so the master sees no acknowledge
  assign ack_now = byte_done && (((state_ff == eef_pkg::EEF_ST_DEVADR) && dev_ok)
                   || (state_ff == eef_pkg::EEF_ST_WADR)
                   || ((state_ff == eef_pkg::EEF_ST_DATA) && (fifo_ready || guard_s)));
  // guard stops the byte reaching the array
  assign push = byte_done && (state_ff == eef_pkg::EEF_ST_DATA) && fifo_ready && !guard_s;
  assign push_word = '{addr: word_addr_ff, data: shift_ff};
  assign ofs = page_ofs(variant);
  // ****************************************************************
  // bit collection
  // ****************************************************************
  // shift on clock rise, eight bits per word
  always_ff @(posedge mclk) begin
    if (reset) begin
      bit_cnt_ff <= eef_pkg::BIT_CNT_RST;
      shift_ff   <= 8'h00;
    end else if (start_det) begin
      bit_cnt_ff <= eef_pkg::BIT_CNT_RST;
    end else if (scl_rise && (bit_cnt_ff != eef_pkg::BYTE_BITS) && !ack_state) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      shift_ff   <= {shift_ff[6:0], pin_sync_ff.sda};
    end else if (scl_fall && ack_state) begin
      // ninth clock over, next word starts
      bit_cnt_ff <= eef_pkg::BIT_CNT_RST;
    end
  end
  // ****************************************************************
  // state machine
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= eef_pkg::EEF_ST_IDLE;
    end else if (start_det) begin
      state_ff <= eef_pkg::EEF_ST_DEVADR;
    end else if (stop_det) begin
      state_ff <= eef_pkg::EEF_ST_IDLE;
    end else begin
      case (state_ff)
        eef_pkg::EEF_ST_IDLE: state_ff <= eef_pkg::EEF_ST_IDLE;
        eef_pkg::EEF_ST_DEVADR: begin
          // mismatch waits for the next start
          if (byte_done) begin
            state_ff <= dev_ok ? eef_pkg::EEF_ST_DEVACK : eef_pkg::EEF_ST_IDLE;
          end
        end
        eef_pkg::EEF_ST_DEVACK: begin
          if (scl_fall) begin
            state_ff <= shift_ff[0] ? eef_pkg::EEF_ST_READ : eef_pkg::EEF_ST_WADR;
          end
        end
        eef_pkg::EEF_ST_WADR: begin
          if (byte_done) begin
            state_ff <= eef_pkg::EEF_ST_WACK;
          end
        end
        eef_pkg::EEF_ST_WACK, eef_pkg::EEF_ST_DACK: begin
          if (scl_fall) begin
            state_ff <= eef_pkg::EEF_ST_DATA;
          end
        end
        eef_pkg::EEF_ST_DATA: begin
          // a refused byte leaves the bus until the next start
          if (byte_done) begin
            state_ff <= ack_now ? eef_pkg::EEF_ST_DACK : eef_pkg::EEF_ST_IDLE;
          end
        end
        // reading is served elsewhere; line stays released
        eef_pkg::EEF_ST_READ: state_ff <= eef_pkg::EEF_ST_READ;
        default: state_ff <= eef_pkg::EEF_ST_IDLE;
      endcase
    end
  end
  // ****************************************************************
  // data line drive
  // ****************************************************************
  // only a low is ever driven
  always_ff @(posedge mclk) begin
    sda_out_ff <= 1'b0;
  end
  // pull low after eighth fall, release after ninth
  always_ff @(posedge mclk) begin
    if (reset || start_det || stop_det) begin
      sda_oe_ff <= 1'b0;
    end else if (ack_now) begin
      sda_oe_ff <= 1'b1;
    end else if (scl_fall && ack_state) begin
      sda_oe_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // word address
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      page_ff      <= eef_pkg::WORD_ADDR_RST;
      word_addr_ff <= eef_pkg::WORD_ADDR_RST;
      read_mode_ff <= 1'b0;
    end else if ((state_ff == eef_pkg::EEF_ST_DEVADR) && byte_done && dev_ok) begin
      page_ff      <= page_bits(variant, shift_ff[3:1]);
      read_mode_ff <= shift_ff[0];
    end else if ((state_ff == eef_pkg::EEF_ST_WADR) && byte_done) begin
      // page on top, cut to array size
      word_addr_ff <= (page_ff | {3'h0, shift_ff}) & array_mask(variant);
    end else if ((state_ff == eef_pkg::EEF_ST_DATA) && ack_now) begin
      // offset wraps inside its page, page row is kept
      word_addr_ff <= (word_addr_ff & ~ofs) | ((word_addr_ff + 11'h001) & ofs);
    end
  end

  // ****************************************************************
  // status
  // ****************************************************************
  // standby from power-up, again once idle and not writing
  always_ff @(posedge mclk) begin
    if (reset) begin
      standby_ff   <= 1'b1;
      selected_ff  <= 1'b0;
      guard_hit_ff <= 1'b0;
    end else begin
      standby_ff   <= (state_ff == eef_pkg::EEF_ST_IDLE) && !write_busy;
      selected_ff  <= (state_ff != eef_pkg::EEF_ST_IDLE) && (state_ff != eef_pkg::EEF_ST_DEVADR);
      guard_hit_ff <= byte_done && (state_ff == eef_pkg::EEF_ST_DATA) && guard_s;
    end
  end
  // ****************************************************************
  // write fifo, back-pressure turns into a missing acknowledge
  // ****************************************************************
  eef_fifo #(
    .WIDTH ($bits(eef_pkg::eef_wr_word_type)),
    .DEPTH (eef_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_word)
  );
  assign sda_out   = sda_out_ff;
  assign sda_oe    = sda_oe_ff;
  assign standby   = standby_ff;
  assign selected  = selected_ff;
  assign read_mode = read_mode_ff;
  assign word_addr = word_addr_ff;
  assign guard_hit = guard_hit_ff;
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_low_only_drive: assert property (sda_out_ff == 1'b0)
    else $error("data line driven high");
  a_ack_on_fall: assert property ($rose(sda_oe_ff) |-> $past(scl_fall) && $past(bit_cnt_ff) == 4'h8)
    else $error("acknowledge not after eighth falling clock");
  a_drive_clk_low: assert property ($changed(sda_oe_ff) && !$past(start_det) && !$past(stop_det)
    |-> !pin_sync_ff.scl)
    else $error("drive changed with clock high");
  a_start_restart: assert property (start_det |=> state_ff == eef_pkg::EEF_ST_DEVADR
    && bit_cnt_ff == 4'h0 && !sda_oe_ff)
    else $error("start did not restart address");
  a_stop_standby: assert property (stop_det && !write_busy |=> ##1 standby_ff)
    else $error("stop did not reach standby");
  a_nack_mismatch: assert property (state_ff == eef_pkg::EEF_ST_DEVADR && byte_done && !dev_ok
    |=> !sda_oe_ff && state_ff == eef_pkg::EEF_ST_IDLE)
    else $error("mismatch was acknowledged");
  a_busy_no_ack: assert property (state_ff == eef_pkg::EEF_ST_DEVADR && byte_done && write_busy
    |=> !sda_oe_ff)
    else $error("acknowledge during internal write");
  a_guard_blocks: assert property ($past(guard_s) |-> u_fifo.count_ff <= $past(u_fifo.count_ff))
    else $error("write passed while guarded");
  a_page_kept: assert property (state_ff == eef_pkg::EEF_ST_DATA && ack_now
    |=> (word_addr_ff & ~ofs) == ($past(word_addr_ff) & ~ofs))
    else $error("page row moved during write");
  a_addr_in_array: assert property (state_ff == eef_pkg::EEF_ST_WADR && byte_done
    |=> (word_addr_ff & ~array_mask(variant)) == 11'h000)
    else $error("word address beyond array");
  c_header_ack: cover property (state_ff == eef_pkg::EEF_ST_DEVACK && scl_fall);
  c_byte_pushed: cover property (push);
  c_fifo_full: cover property (!fifo_ready);
  c_read_header: cover property (state_ff == eef_pkg::EEF_ST_READ);
endmodule : eef_bus_front_end

// *** design/eef_pkg.sv ***
// constants, types and state encodings shared by the serial memory bus front end
package eef_pkg;

  // ****************************************************************
  // framing
  // ****************************************************************
  localparam logic [3:0]  BYTE_BITS     = 4'h8;     // bits in every address or data word
  localparam logic [3:0]  BIT_CNT_RST   = 4'h0;     // bit counter after reset or start
  localparam int unsigned FIFO_DEPTH    = 16;       // received words held before the array side
  localparam int unsigned WORD_ADDR_W   = 11;       // widest word address of the family
  localparam logic [3:0]  DEV_TYPE_RST  = 4'h5;     // type code default, value is arbitrary

  // ****************************************************************
  // array organisation per density
  // ****************************************************************
  localparam logic [10:0] ARRAY_MASK_S  = 11'h0ff;  // 32 pages of 8 bytes
  localparam logic [10:0] ARRAY_MASK_M  = 11'h1ff;  // 32 pages of 16 bytes
  localparam logic [10:0] ARRAY_MASK_L  = 11'h3ff;  // 64 pages of 16 bytes
  localparam logic [10:0] ARRAY_MASK_XL = 11'h7ff;  // 128 pages of 16 bytes
  localparam logic [10:0] PAGE_OFS_8    = 11'h007;  // byte offset inside an 8-byte page
  localparam logic [10:0] PAGE_OFS_16   = 11'h00f;  // byte offset inside a 16-byte page
  localparam logic [10:0] WORD_ADDR_RST = 11'h000;  // word address after reset

  // ****************************************************************
  // types
  // ****************************************************************
  // density variant, picks strap compare and page bits
  typedef enum logic [1:0] {
    EEF_VAR_S  = 2'h0,
    EEF_VAR_M  = 2'h1,
    EEF_VAR_L  = 2'h2,
    EEF_VAR_XL = 2'h3
  } eef_variant_type;

  // bus states, gray coded along the write path
  typedef enum logic [2:0] {
    EEF_ST_IDLE   = 3'h0,
    EEF_ST_DEVADR = 3'h1,
    EEF_ST_DEVACK = 3'h3,
    EEF_ST_WADR   = 3'h2,
    EEF_ST_WACK   = 3'h6,
    EEF_ST_DATA   = 3'h7,
    EEF_ST_DACK   = 3'h5,
    EEF_ST_READ   = 3'h4
  } eef_state_type;

  // bus pin pair as sampled
  typedef struct packed {
    logic scl;
    logic sda;
  } eef_pins_type;

  // one received write byte with its array address
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0]  data;
  } eef_wr_word_type;

endpackage : eef_pkg

// *** testbench/eef_master_model.sv ***
// two-wire bus master model for the serial memory front end
`timescale 1ns/10ps
module eef_master_model (
  output logic     scl,
  output logic     sda_rel,
  input  wire logic sda_line
);
  // ****************************************************************
  // bus cycles, 48 ns bit split in 12 ns quarters, free of mclk phase
  // ****************************************************************
  // both lines idle released
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic bit_io(input logic b, output logic seen);
    sda_rel <= b;
    #12 scl <= 1'b1;
    #12 seen = sda_line;
    #12 scl <= 1'b0;
    #12;
  endtask : bit_io
  task automatic start();
    sda_rel <= 1'b1;
    #12 scl <= 1'b1;
    #12 sda_rel <= 1'b0;
    #12 scl <= 1'b0;
    #12;
  endtask : start
  // stop, data rises with clock high
  task automatic stop();
    sda_rel <= 1'b0;
    #12 scl <= 1'b1;
    #12 sda_rel <= 1'b1;
    #24;
  endtask : stop
  // clock until the line reads high, nine times at most; a start follows
  task automatic recover();
    logic s;
    s = 1'b0;
    for (int i = 0; i < 9 && !s; i++) bit_io(1'b1, s);
  endtask : recover
  // msb first, ninth clock released so the device may acknowledge
  task automatic byte_io(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : byte_io
endmodule : eef_master_model

// *** testbench/tb_top.sv ***
// self-checking bench for the serial memory bus front end
`timescale 1ns/10ps
module tb_top;
  localparam logic [3:0] TYPE_CODE = 4'h6;  // arbitrary type code
  logic                     mclk = 1'b0;
  logic                     reset = 1'b1;
  logic                     scl, sda_rel, sda_out, sda_oe, k, hold = 1'b0;
  logic [2:0]               straps = 3'h0;
  logic                     write_guard = 1'b0, write_busy = 1'b0;
  eef_pkg::eef_variant_type variant = eef_pkg::EEF_VAR_S;
  logic                     wr_valid, wr_ready = 1'b0, standby, selected, read_mode, guard_hit;
  eef_pkg::eef_wr_word_type wr_word;
  logic [10:0]              word_addr;
  logic [31:0]              seed = 32'hdd61af10, rnd = 32'hdd61af10;
  logic [18:0]              exp_q[$];  // expected stored words, oldest first
  int                       fails = 0, compares = 0, gh = 0;
  // open-drain line with pull-up: low if anyone pulls
  wire sda_line = sda_rel & ~(sda_oe & ~sda_out);
  always #2.5 mclk = ~mclk;
  eef_bus_front_end #(.DEV_TYPE(TYPE_CODE)) eef_bus_front_end_inst (
    .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_bit_high(straps[2]), .strap_bit_mid(straps[1]), .strap_bit_low(straps[0]),
    .write_guard(write_guard), .variant(variant), .write_busy(write_busy), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_word(wr_word), .standby(standby), .selected(selected),
    .read_mode(read_mode), .word_addr(word_addr), .guard_hit(guard_hit));
  eef_master_model eef_master_model_inst (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // page-bit mask: as many low header bits as the variant number
  function automatic logic [2:0] pm(input logic [1:0] v);
    return 3'((4'h1 << v) - 4'h1);
  endfunction : pm
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // bounded wait for the consumer side to take every expected word
  task automatic drain();
    for (int i = 0; i < 600 && exp_q.size() != 0; i++) @(posedge mclk);
    if (exp_q.size() != 0) begin
      fails++;
      test_done();
    end
    repeat (4) @(posedge mclk);
  endtask : drain
  // header, word address, n data bytes; a full fifo refuses the 17th
  task automatic wr_seq(input logic [1:0] v, input logic [2:0] pg, input logic [7:0] ab, input int n);
    logic [10:0] a;
    logic [10:0] ofs;
    logic [7:0]  d;
    a = {pg & pm(v), ab} & ((11'h100 << v) - 11'h1);
    ofs = (v == 2'h0) ? 11'h007 : 11'h00f;
    eef_master_model_inst.start();
    eef_master_model_inst.byte_io({TYPE_CODE, (straps & ~pm(v)) | (pg & pm(v)), 1'b0}, k);
    check(k, 1'b1);
    eef_master_model_inst.byte_io(ab, k);
    check(k, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = seed[7:0];
      seed = lfsr(seed);
      // note first: the consumer may take the word during the ninth clock
      if (i < 16 && !write_guard) exp_q.push_back({a, d});
      eef_master_model_inst.byte_io(d, k);
      check(k, 19'(i < 16));
      a = (a & ~ofs) | ((a + 11'h1) & ofs);
    end
    eef_master_model_inst.stop();
  endtask : wr_seq
  // random consumer stalls, or a full stall while hold is set
  always @(posedge mclk) begin
    rnd <= lfsr(rnd);
    wr_ready <= ~hold & rnd[0];
  end
  // monitor: every taken word must match the oldest note
  always @(posedge mclk) begin
    if (guard_hit === 1'b1) gh++;
    if (!reset && wr_valid === 1'b1 && wr_ready === 1'b1)
      check(wr_word, exp_q.size() != 0 ? exp_q.pop_front() : ~wr_word);
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    check(standby, 1'b1);
    for (int v = 0; v < 4; v++) begin
      variant <= eef_pkg::eef_variant_type'(v);
      straps <= seed[2:0];
      seed = lfsr(seed);
      @(posedge mclk);
      wr_seq(2'(v), seed[10:8], seed[7:0] | 8'h0f, 2);
      drain();
      check(standby, 1'b1);
    end
    // wrong type code, then wrong straps on the smallest part
    variant <= eef_pkg::EEF_VAR_S;
    for (int j = 0; j < 2; j++) begin
      eef_master_model_inst.start();
      eef_master_model_inst.byte_io({j ? TYPE_CODE : ~TYPE_CODE, straps ^ 3'(j), 1'b0}, k);
      check(k, 1'b0);
      check(selected, 1'b0);
      check(standby, 1'b1);
    end
    // partial header cut by a new start
    eef_master_model_inst.start();
    repeat (3) eef_master_model_inst.bit_io(1'b1, k);
    eef_master_model_inst.recover();
    wr_seq(2'h0, 3'h0, seed[7:0], 1);
    drain();
    write_busy <= 1'b1;
    eef_master_model_inst.start();
    eef_master_model_inst.byte_io({TYPE_CODE, straps, 1'b0}, k);
    check(k, 1'b0);
    write_busy <= 1'b0;
    write_guard <= 1'b1;
    gh = 0;
    wr_seq(2'h0, 3'h0, seed[15:8], 2);
    drain();
    check(19'(gh), 19'h2);
    write_guard <= 1'b0;
    eef_master_model_inst.start();
    eef_master_model_inst.byte_io({TYPE_CODE, straps, 1'b1}, k);
    check(k, 1'b1);
    check(read_mode, 1'b1);
    eef_master_model_inst.stop();
    repeat (4) @(posedge mclk);
    check(standby, 1'b1);
    hold <= 1'b1;
    variant <= eef_pkg::EEF_VAR_XL;
    wr_seq(2'h3, seed[18:16], seed[7:0], 17);
    hold <= 1'b0;
    drain();
    test_done();
  end
  // hang guard
  initial begin
    #300000;
    fails++;
    test_done();
  end
endmodule : tb_top
